// ==== design/adc_input_ref_clock_config.sv ====
// The APB slave port was decided locally.
`include "adc_cfg_defs.svh"
module adc_input_ref_clock_config #(
	parameter int NUM_CH = 16,
	parameter int CONV_CYCLES = `CONV_CYCLES
) (
	input wire logic sys_clk, // 20 MHz system clock
	input wire logic sys_rst, // async reset, active high
	input wire logic psel, // apb select
	input wire logic penable, // apb access phase
	input wire logic pwrite, // apb direction
	input wire logic [11:0] paddr, // apb byte address
	input wire logic [31:0] pwdata, // apb write data
	output logic [31:0] prdata, // apb read data
	output logic pready, // apb ready
	output logic pslverr, // apb error, unmapped address
	input wire logic xtalOk, // external crystal or clock present
	output logic [4:0] posInputSel, // selector pin to positive side
	output logic [4:0] negInputSel, // selector pin to negative side
	output logic [3:0] activeChannel, // channel being converted
	output logic convStart, // pulse at start of each conversion
	output logic positiveInputBufferEnable, // positive buffer on
	output logic negativeInputBufferEnable, // negative buffer on
	output adc_cfg_pkg::ref_src_t referenceSourceSelect, // reference used
	output logic intRefEnable, // internal reference powered
	output logic referenceOutputPinEnable, // drive reference output pin
	output adc_cfg_pkg::clk_src_t masterClockSourceSelect, // clock src
	output logic crystalClockIoPinOut, // clock level out on pin
	output logic crystalClockIoPinOeN // pin output enable, low drives
);
	logic [15:0] modeReg_r;
	logic [15:0] setupReg_r;
	logic [15:0] chanReg_r [NUM_CH];
	logic [3:0] curCh_r;
	logic [3:0] nextCh;
	logic [15:0] convCnt_r;
	logic anyEn;
	logic [NUM_CH-1:0] enVec;
	logic oscDiv_r;

	// apb decode
	wire logic [9:0] idx = paddr[11:2];
	wire logic access = psel && penable;
	wire logic hitMode = idx == 10'(`IDX_MODE);
	wire logic hitSetup = idx == 10'(`IDX_SETUP0);
	wire logic hitStat = idx == 10'(`IDX_SEQ_STAT);
	wire logic hitCh = idx >= 10'(`IDX_CH_BASE) &&
		idx < 10'(`IDX_CH_BASE) + 10'(NUM_CH);
	wire logic [3:0] chIdx = 4'(idx - 10'(`IDX_CH_BASE));
	wire logic mapped = hitMode || hitSetup || hitStat || hitCh;
	wire logic wrEn = access && pwrite && mapped && !hitStat;

	assign pready = 1'b1;
	assign pslverr = access && !mapped;

	// next enabled channel above cur, wrapping to lowest
	function automatic logic [3:0] nextEnabled(input logic [NUM_CH-1:0] en,
		input logic [3:0] cur);
		logic [3:0] res;
		logic found;
		logic [3:0] c;
		res = cur;
		found = 1'b0;
		for (int i = 1; i <= NUM_CH; i++) begin
			c = 4'((int'(cur) + i) % NUM_CH);
			if (!found && en[c]) begin
				res = c;
				found = 1'b1;
			end
		end
		return res;
	endfunction

	always_comb begin
		for (int i = 0; i < NUM_CH; i++)
			enVec[i] = chanReg_r[i][`CH_EN_BIT];
	end
	assign anyEn = |enVec;
	assign nextCh = nextEnabled(enVec, curCh_r);

	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			modeReg_r <= `RST_MODE;
			setupReg_r <= `RST_SETUP0;
		end else if (wrEn && hitMode) begin
			modeReg_r <= pwdata[15:0];
		end else if (wrEn && hitSetup) begin
			setupReg_r <= pwdata[15:0];
		end
	end

	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			for (int i = 0; i < NUM_CH; i++)
				chanReg_r[i] <= (i == 0) ? `RST_CHAN0 : `RST_CHAN;
		end else if (wrEn && hitCh) begin
			chanReg_r[chIdx] <= pwdata[15:0];
		end
	end

	// conversion pacing; CONV_CYCLES system clocks per conversion (20 us at 20 MHz)
	wire logic convDone = convCnt_r == 16'(CONV_CYCLES - 1);
	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			convCnt_r <= 16'h0000;
			curCh_r <= 4'h0;
			convStart <= 1'b0;
		end else begin
			convStart <= anyEn && convDone;
			if (!anyEn || convDone)
				convCnt_r <= 16'h0000;
			else
				convCnt_r <= convCnt_r + 16'h0001;
			if (anyEn && (convDone || !enVec[curCh_r]))
				curCh_r <= nextCh;
		end
	end

	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			posInputSel <= 5'h00;
			negInputSel <= 5'h01;
			activeChannel <= 4'h0;
		end else begin
			// any of 17 pins either side
			posInputSel <= chanReg_r[curCh_r][`CH_POS_HI:`CH_POS_LO];
			negInputSel <= chanReg_r[curCh_r][`CH_NEG_HI:`CH_NEG_LO];
			activeChannel <= curCh_r;
		end
	end

	assign positiveInputBufferEnable = setupReg_r[`SETUP_BUFP_BIT];
	assign negativeInputBufferEnable = setupReg_r[`SETUP_BUFN_BIT];
	assign referenceSourceSelect = adc_cfg_pkg::ref_src_t'(
		setupReg_r[`SETUP_REFSEL_HI:`SETUP_REFSEL_LO]);
	assign intRefEnable = modeReg_r[`MODE_REFEN_BIT];
	assign referenceOutputPinEnable = modeReg_r[`MODE_REFEN_BIT];

	// external sources fall back to oscillator when absent
	wire logic [1:0] clkSel = modeReg_r[`MODE_CLKSEL_HI:`MODE_CLKSEL_LO];
	wire logic extSel = clkSel[1];
	assign masterClockSourceSelect = (extSel && !xtalOk) ?
		adc_cfg_pkg::CLK_INT_OSC : adc_cfg_pkg::clk_src_t'(clkSel);

	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst)
			oscDiv_r <= 1'b0;
		else
			oscDiv_r <= ~oscDiv_r;
	end
	assign crystalClockIoPinOut = oscDiv_r;
	assign crystalClockIoPinOeN = !(masterClockSourceSelect ==
		adc_cfg_pkg::CLK_INT_OSC_OUT);

	wire logic [31:0] rdMux =
		hitMode ? {16'h0000, modeReg_r} :
		hitSetup ? {16'h0000, setupReg_r} :
		hitCh ? {16'h0000, chanReg_r[chIdx]} :
		hitStat ? {27'h0000000, anyEn, curCh_r} : 32'h00000000;
	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst)
			prdata <= 32'h00000000;
		else if (psel && !penable && !pwrite)
			prdata <= rdMux;
	end

	reference_output_pin_follows_en_a: assert property (@(posedge sys_clk)
		disable iff (sys_rst) referenceOutputPinEnable == intRefEnable)
		else $error("reference output not tied to enable");
	seq_enabled_only_a: assert property (@(posedge sys_clk)
		disable iff (sys_rst) convStart |-> $past(enVec[nextCh]))
		else $error("converting disabled channel");
	single_ch_stays_a: assert property (@(posedge sys_clk)
		disable iff (sys_rst) ($onehot(enVec) && $stable(enVec) &&
		enVec[curCh_r]) |=> $stable(curCh_r))
		else $error("single channel moved");
	mode_write_a: assert property (@(posedge sys_clk)
		disable iff (sys_rst) (wrEn && hitMode) |=>
		modeReg_r == $past(pwdata[15:0]))
		else $error("mode write lost");
	clk_pin_oe_a: assert property (@(posedge sys_clk)
		disable iff (sys_rst) !crystalClockIoPinOeN |->
		clkSel == 2'h1)
		else $error("clock pin driven wrongly");

	// lowest and highest enabled channel, for scan order checks
	function automatic logic [3:0] lowestEnabled(
		input logic [NUM_CH-1:0] en);
		logic [3:0] res;
		res = 4'h0;
		for (int i = NUM_CH - 1; i >= 0; i--) begin
			if (en[i])
				res = 4'(i);
		end
		return res;
	endfunction

	function automatic logic [3:0] highestEnabled(
		input logic [NUM_CH-1:0] en);
		logic [3:0] res;
		res = 4'h0;
		for (int i = 0; i < NUM_CH; i++) begin
			if (en[i])
				res = 4'(i);
		end
		return res;
	endfunction

	wire logic [3:0] loEn = lowestEnabled(enVec);
	wire logic [3:0] hiEn = highestEnabled(enVec);

	// register writes land as written
	setup_write_a: assert property (@(posedge sys_clk)
		disable iff (sys_rst)
		(wrEn && hitSetup) |=> setupReg_r == $past(pwdata[15:0]))
		else $error("setup write lost");

	refsel_write_a: assert property (@(posedge sys_clk)
		disable iff (sys_rst)
		(wrEn && hitSetup) |=> referenceSourceSelect == adc_cfg_pkg::ref_src_t'(
		$past(pwdata[`SETUP_REFSEL_HI:`SETUP_REFSEL_LO])))
		else $error("reference select not taken");

	bufp_write_a: assert property (@(posedge sys_clk)
		disable iff (sys_rst)
		(wrEn && hitSetup) |=>
		positiveInputBufferEnable == $past(pwdata[`SETUP_BUFP_BIT]))
		else $error("positive buffer enable wrong");

	bufn_write_a: assert property (@(posedge sys_clk)
		disable iff (sys_rst)
		(wrEn && hitSetup) |=>
		negativeInputBufferEnable == $past(pwdata[`SETUP_BUFN_BIT]))
		else $error("negative buffer enable wrong");

	refen_write_a: assert property (@(posedge sys_clk)
		disable iff (sys_rst)
		(wrEn && hitMode) |=> intRefEnable == $past(pwdata[`MODE_REFEN_BIT]))
		else $error("reference enable not taken");

	clksel_write_a: assert property (@(posedge sys_clk)
		disable iff (sys_rst)
		(wrEn && hitMode) |=>
		clkSel == $past(pwdata[`MODE_CLKSEL_HI:`MODE_CLKSEL_LO]))
		else $error("clock select not taken");

	chan_write_a: assert property (@(posedge sys_clk)
		disable iff (sys_rst)
		(wrEn && hitCh) |=> chanReg_r[$past(chIdx)] == $past(pwdata[15:0]))
		else $error("channel write lost");

	chan_en_write_a: assert property (@(posedge sys_clk)
		disable iff (sys_rst)
		(wrEn && hitCh) |=> enVec[$past(chIdx)] == $past(pwdata[`CH_EN_BIT]))
		else $error("channel enable not taken");

	// selector and sequencer
	pos_sel_a: assert property (@(posedge sys_clk)
		disable iff (sys_rst)
		1'b1 |=> posInputSel == $past(chanReg_r[curCh_r][`CH_POS_HI:`CH_POS_LO]))
		else $error("positive selector wrong");

	neg_sel_a: assert property (@(posedge sys_clk)
		disable iff (sys_rst)
		1'b1 |=> negInputSel == $past(chanReg_r[curCh_r][`CH_NEG_HI:`CH_NEG_LO]))
		else $error("negative selector wrong");

	act_ch_a: assert property (@(posedge sys_clk)
		disable iff (sys_rst)
		1'b1 |=> activeChannel == $past(curCh_r))
		else $error("active channel lags wrongly");

	scan_ascend_a: assert property (@(posedge sys_clk)
		disable iff (sys_rst)
		(anyEn && convDone && enVec[curCh_r] && curCh_r != hiEn) |=>
		curCh_r > $past(curCh_r))
		else $error("scan not ascending");

	scan_wrap_a: assert property (@(posedge sys_clk)
		disable iff (sys_rst)
		(anyEn && convDone && curCh_r == hiEn) |=> curCh_r == $past(loEn))
		else $error("scan did not wrap to lowest");

	leave_disabled_a: assert property (@(posedge sys_clk)
		disable iff (sys_rst)
		(anyEn && !enVec[curCh_r]) |=> curCh_r != $past(curCh_r))
		else $error("stuck on disabled channel");

	idle_no_start_a: assert property (@(posedge sys_clk)
		disable iff (sys_rst)
		!anyEn |=> !convStart)
		else $error("conversion with no channel");

	conv_count_a: assert property (@(posedge sys_clk)
		disable iff (sys_rst)
		convStart |-> convCnt_r == 16'h0000)
		else $error("conversion pacing off");

	// clock source and clock pin
	clk_fallback_a: assert property (@(posedge sys_clk)
		disable iff (sys_rst)
		(clkSel[1] && !xtalOk) |-> masterClockSourceSelect ==
		adc_cfg_pkg::CLK_INT_OSC)
		else $error("no fallback to oscillator");

	oe_when_out_a: assert property (@(posedge sys_clk)
		disable iff (sys_rst)
		(masterClockSourceSelect == adc_cfg_pkg::CLK_INT_OSC_OUT) |->
		!crystalClockIoPinOeN)
		else $error("clock pin not driven");

	clk_out_toggle_a: assert property (@(posedge sys_clk)
		disable iff (sys_rst)
		1'b1 |=> crystalClockIoPinOut != $past(crystalClockIoPinOut))
		else $error("clock out not toggling");
endmodule

// ==== design/adc_cfg_defs.svh ====
`ifndef ADC_CFG_DEFS_SVH
`define ADC_CFG_DEFS_SVH
// register indices (printed offsets), byte address = 4 * index
`define IDX_MODE 8'h01
`define IDX_SETUP0 8'h20
`define IDX_CH_BASE 8'h10
`define IDX_SEQ_STAT 8'h40
`define RST_MODE 16'hA000
`define RST_SETUP0 16'h1320
`define RST_CHAN0 16'h8001
`define RST_CHAN 16'h0001
// mode register fields
`define MODE_REFEN_BIT 15
`define MODE_CLKSEL_HI 3
`define MODE_CLKSEL_LO 2
// setup register fields
`define SETUP_REFSEL_HI 5
`define SETUP_REFSEL_LO 4
`define SETUP_BUFP_BIT 9
`define SETUP_BUFN_BIT 8
// channel register fields
`define CH_EN_BIT 15
`define CH_POS_HI 9
`define CH_POS_LO 5
`define CH_NEG_HI 4
`define CH_NEG_LO 0
// master clock, system clock and conversion timing
`define MCLK_NOMINAL_HZ 16000000
`define SYS_CLK_HZ 20000000
`define CONV_TIME_US 20
`define CONV_CYCLES ((`CONV_TIME_US * (`SYS_CLK_HZ / 1000000)))
`endif

// ==== design/adc_cfg_pkg.sv ====
package adc_cfg_pkg;
	typedef enum logic [1:0] {
		CLK_INT_OSC,
		CLK_INT_OSC_OUT,
		CLK_EXT_CLOCK,
		CLK_EXT_XTAL
	} clk_src_t;
	typedef enum logic [1:0] {
		REF_EXT1,
		REF_EXT2,
		REF_INTERNAL,
		REF_SUPPLY
	} ref_src_t;
endpackage

// ==== bench/tb_top.sv ====
module tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	logic sysClk = 0, sysRst = 1, psel = 0, penable = 0, pwrite = 0;
	logic xtalOk = 0, err, pready, pslverr, convStart, posBuf, negBuf;
	logic intRef, reference_output_pin, pinOut, pinOeN, p;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0000_0000, prdata, rd, v;
	logic [15:0] m;
	logic [15:0] chReg [16];
	logic [4:0] posSel, negSel;
	logic [3:0] actCh, c;
	adc_cfg_pkg::ref_src_t refSel;
	adc_cfg_pkg::clk_src_t clkSel;
	int badCount = 0, compares = 0, cycles = 0;
	adc_input_ref_clock_config #(.CONV_CYCLES(8)) dut (.sys_clk(sysClk),
		.sys_rst(sysRst), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .xtalOk(xtalOk), .posInputSel(posSel),
		.negInputSel(negSel), .activeChannel(actCh), .convStart(convStart),
		.positiveInputBufferEnable(posBuf), .negativeInputBufferEnable(negBuf),
		.referenceSourceSelect(refSel), .intRefEnable(intRef),
		.referenceOutputPinEnable(reference_output_pin), .masterClockSourceSelect(clkSel),
		.crystalClockIoPinOut(pinOut), .crystalClockIoPinOeN(pinOeN));
	initial forever #25 sysClk = ~sysClk;
	always @(posedge sysClk) begin
		cycles++;
		if (cycles == 20000) begin
			badCount++;
			wrapUp();
		end
	end
	task automatic check(input string nm, input logic [31:0] seen, exp);
		compares++;
		if (seen !== exp) begin
			badCount++;
			$display("wrong value %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	// one apb transfer, then one idle edge
	task automatic apb(input logic wr, input logic [11:0] a,
		input logic [31:0] d);
		psel <= 1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge sysClk);
		penable <= 1;
		do @(posedge sysClk); while (pready !== 1);
		rd = prdata;
		err = pslverr;
		psel <= 0;
		penable <= 0;
		@(posedge sysClk);
	endtask
	function automatic logic [3:0] nextCh(input logic [15:0] msk,
		input logic [3:0] cur);
		for (int i = 1; i <= 16; i++) begin
			if (msk[4'(cur + i)]) return 4'(cur + i);
		end
		return cur;
	endfunction
	task automatic waitConv;
		do @(posedge sysClk); while (convStart !== 1);
		repeat (2) @(posedge sysClk);
	endtask
	task wrapUp;
		$display("compares %0d bad %0d", compares, badCount);
		if (badCount == 0 && compares > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask
	initial begin
		void'($urandom(77275));
		repeat (10) @(posedge sysClk);
		sysRst <= 0;
		@(posedge sysClk);
		check("clock source", clkSel, 0);
		check("reference", refSel, 2);
		check("reference_output_pin", reference_output_pin, 1);
		check("pin oe", pinOeN, 1);
		apb(0, 12'h004, 0);
		check("mode", rd, 32'h0000_A000);
		apb(0, 12'h080, 0);
		check("setup0", rd, 32'h0000_1320);
		apb(0, 12'h044, 0);
		check("chan1", rd, 32'h0000_0001);
		apb(0, 12'hFFC, 0);
		check("unmapped", {err, pready, rd[29:0]}, 32'hC000_0000);
		for (int k = 0; k < 16; k++) begin
			xtalOk <= k[2];
			apb(1, 12'h004, {16'h0000, k[3], 11'h000, k[1:0], 2'b00});
			check("ref enable", intRef, k[3]);
			check("reference_output_pin", reference_output_pin, k[3]);
			check("clock", clkSel, (k[1] && !k[2]) ? 0 : k[1:0]);
			check("pin oe", pinOeN, k[1:0] != 1);
			p = pinOut;
			@(posedge sysClk);
			if (k[1:0] == 1) check("clock out", pinOut, !p);
		end
		repeat (6) begin
			v = $urandom;
			apb(1, 12'h080, v);
			check("reference", refSel, v[5:4]);
			check("buffers", {posBuf, negBuf}, v[9:8]);
		end
		for (int t = 0; t < 4; t++) begin
			m = t == 0 ? 16'h0001 << ($urandom % 16) : 16'(t == 1 ? 32'h8001
				: $urandom | 1);
			for (int i = 0; i < 16; i++) begin
				chReg[i] = {m[i], 5'h00, 5'($urandom % 17), 5'($urandom % 17)};
				apb(1, 12'(12'h040 + 4 * i), {16'h0000, chReg[i]});
			end
			apb(0, 12'h04C, 0);
			check("chan rd", rd, {16'h0000, chReg[3]});
			waitConv();
			waitConv();
			c = actCh;
			repeat (6) begin
				waitConv();
				check("channel", actCh, nextCh(m, c));
				check("pos pin", posSel, chReg[actCh][9:5]);
				check("neg pin", negSel, chReg[actCh][4:0]);
				c = actCh;
			end
		end
		apb(0, 12'h100, 0);
		check("status", rd[4], 1);
		wrapUp();
	end
endmodule
